// ===== bay_pkg.sv
package bay_pkg;

  // Sample and byte geometry of the packed 12-bit raw format
  localparam int PIX_W  = 12;
  localparam int BYTE_W = 8;
  localparam int NIB_W  = 4;
  localparam int HI_LSB = 4;

  // Unsigned sample range, code equals signal level
  localparam logic [PIX_W-1:0] PIX_MIN = 12'h000;
  localparam logic [PIX_W-1:0] PIX_MAX = 12'hfff;

  // Fill for the unused nibble of a row that ends on an even pixel
  localparam logic [NIB_W-1:0] NIB_PAD = 4'h0;

  // Row parity: even rows carry blue/green, odd rows green/red
  localparam logic ROW_EVEN = 1'b0;
  localparam logic ROW_ODD  = 1'b1;

  // Depth of the output buffer
  localparam int FIFO_DEPTH = 2;

  // Packer sequence
  typedef enum logic [1:0] {
    S_EVEN = 2'b00,
    S_ODD  = 2'b01,
    S_HI3  = 2'b10,
    S_TAIL = 2'b11
  } bay_state_t;

endpackage

// ===== bay_packer.sv
// Notes on behaviour
// - Every pixel delivers exactly twelve bits of sample value.
// - Two consecutive pixels of a row become three consecutive bytes, no padding.
// - Samples pass raw: own filter colour only, no interpolation or conversion.
// - Byte one holds even pixel bits 11..4; byte three holds odd pixel bits 11..4.
// - Middle byte joins low nibbles of the odd pixel and the preceding even pixel.
// - Even rows: even positions blue, odd positions green, alternating.
// - Odd rows: even positions green, odd positions red, alternating.
// - Packing restarts every row; last byte completes the last pixel.
// - Samples are unsigned 0x000 to 0xfff, code equals signal level.
`timescale 1ns/100ps

module bay_packer
  import bay_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // Sensor pixel stream
  input  wire logic              pix_valid,
  output logic                   pix_ready,
  input  wire logic [PIX_W-1:0]  pix_data,
  input  wire logic              pix_sof,
  input  wire logic              pix_last,
  // Packed byte stream toward the host buffer
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic [BYTE_W-1:0]      out_data,
  output logic                   out_last,
  output logic                   out_row_odd
);

  localparam int ENT_W = BYTE_W + 2;
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  //////////////////////////////////////////////////////////////////////////////

  bay_state_t              state;
  bay_state_t              next_state;
  logic [PIX_W-1:0]        even_px;
  logic [BYTE_W-1:0]       hi_px;
  logic                    last_q;
  logic                    cur_row;
  logic                    row_odd;
  logic                    row_sel;
  logic                    acc;
  logic                    push;
  logic [BYTE_W-1:0]       push_byte;
  logic                    push_last;
  logic                    push_row;
  logic [ENT_W-1:0]        push_ent;
  logic                    pop;
  logic                    fifo_space;
  logic [ENT_W-1:0]        mem [DEPTH];
  logic [PTR_W-1:0]        wr_ptr;
  logic [PTR_W-1:0]        rd_ptr;
  logic [CNT_W-1:0]        count;
  logic [PTR_W-1:0]        next_wr_ptr;
  logic [PTR_W-1:0]        next_rd_ptr;
  logic [CNT_W-1:0]        next_count;
  logic [ENT_W-1:0]        next_head;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign acc        = pix_valid && pix_ready;
  assign pop        = out_valid && out_ready;
  assign fifo_space = count < CNT_W'(DEPTH);
  // Start of frame only counts on the first pixel of a pair
  assign row_sel    = (pix_sof && state == S_EVEN) ? ROW_EVEN : row_odd;

  //////////////////////////////////////////////////////////////////////////////
  // Pair packer

  always_comb begin
    next_state = state;
    push       = 1'b0;
    push_byte  = '0;
    push_last  = 1'b0;
    push_row   = cur_row;
    case (state)
      S_EVEN: begin
        if (acc) begin
          push       = 1'b1;
          push_byte  = pix_data[PIX_W-1:HI_LSB];
          push_row   = row_sel;
          next_state = pix_last ? S_TAIL : S_ODD;
        end
      end
      S_ODD: begin
        if (acc) begin
          push       = 1'b1;
          push_byte  = {pix_data[NIB_W-1:0], even_px[NIB_W-1:0]};
          next_state = S_HI3;
        end
      end
      S_HI3: begin
        if (fifo_space) begin
          push       = 1'b1;
          push_byte  = hi_px;
          push_last  = last_q;
          next_state = S_EVEN;
        end
      end
      S_TAIL: begin
        if (fifo_space) begin
          push       = 1'b1;
          push_byte  = {NIB_PAD, even_px[NIB_W-1:0]};
          push_last  = 1'b1;
          next_state = S_EVEN;
        end
      end
      default: begin
        next_state = S_EVEN;
      end
    endcase
  end

  assign push_ent = {push_row, push_last, push_byte};

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= S_EVEN;
    end else begin
      state <= next_state;
    end
  end

  // Even sample held whole until its partner arrives
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      even_px <= PIX_MIN;
    end else if (acc && state == S_EVEN) begin
      even_px <= pix_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hi_px  <= '0;
      last_q <= 1'b0;
    end else if (acc && state == S_ODD) begin
      hi_px  <= pix_data[PIX_W-1:HI_LSB];
      last_q <= pix_last;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Row parity tracking

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      row_odd <= ROW_EVEN;
    end else if (acc && pix_last) begin
      row_odd <= ~row_sel;
    end else if (acc && pix_sof && state == S_EVEN) begin
      row_odd <= ROW_EVEN;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cur_row <= ROW_EVEN;
    end else if (acc && state == S_EVEN) begin
      cur_row <= row_sel;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output buffer; head is re-registered so the outputs come from flops

  always_comb begin
    next_wr_ptr = push ? ptr_inc(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? ptr_inc(rd_ptr) : rd_ptr;
    next_count  = count + CNT_W'(push) - CNT_W'(pop);
    if (push && next_rd_ptr == wr_ptr) begin
      next_head = push_ent;
    end else begin
      next_head = mem[next_rd_ptr];
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge ref_clk) begin
      if (push && wr_ptr == PTR_W'(i)) begin
        mem[i] <= push_ent;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      out_valid   <= 1'b0;
      out_data    <= '0;
      out_last    <= 1'b0;
      out_row_odd <= ROW_EVEN;
    end else begin
      out_valid   <= next_count != '0;
      out_data    <= next_head[BYTE_W-1:0];
      out_last    <= next_head[BYTE_W];
      out_row_odd <= next_head[BYTE_W+1];
    end
  end

  // Ready looks one cycle ahead, so it is granted only with a free slot in hand
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pix_ready <= 1'b0;
    end else begin
      pix_ready <= (next_state == S_EVEN || next_state == S_ODD) && next_count < CNT_W'(DEPTH);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_even_taken;
    acc && state == S_EVEN;
  endsequence

  sequence s_odd_taken;
    acc && state == S_ODD;
  endsequence

  sequence s_row_end;
    acc && pix_last;
  endsequence

  AST_EVEN_HI: assert property (
    s_even_taken |-> push && push_byte == pix_data[PIX_W-1:HI_LSB])
    else $error("first byte of pair is not even pixel high bits");

  AST_RAW_HOLD: assert property (
    s_even_taken |=> even_px == $past(pix_data) && state != S_EVEN)
    else $error("even sample altered or pair not opened");

  AST_MID_LOW: assert property (
    s_odd_taken |-> push && push_byte[NIB_W-1:0] == even_px[NIB_W-1:0])
    else $error("middle byte lacks even pixel low nibble");

  AST_MID_HIGH: assert property (
    s_odd_taken |-> push_byte[BYTE_W-1:HI_LSB] == pix_data[NIB_W-1:0])
    else $error("odd pixel nibble not in upper half of middle byte");

  AST_ODD_HI: assert property (
    s_odd_taken |=> state == S_HI3 && hi_px == $past(pix_data[PIX_W-1:HI_LSB]))
    else $error("odd pixel high bits not queued as third byte");

  AST_THIRD_PUSH: assert property (
    state == S_HI3 && fifo_space |-> push && push_byte == hi_px && push_last == last_q)
    else $error("third byte not emitted with a free slot");

  AST_NO_OVERRUN: assert property (
    push |-> fifo_space)
    else $error("byte pushed into a full buffer");

  AST_STALL_HOLD: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last))
    else $error("output byte changed while stalled");

  AST_ROW_RESTART: assert property (
    s_row_end |=> state == S_TAIL || state == S_HI3 || (state == S_EVEN && $past(state) == S_HI3))
    else $error("row end did not close the pair");

  AST_TAIL_BYTE: assert property (
    state == S_TAIL && fifo_space |-> push && push_last && push_byte[BYTE_W-1:HI_LSB] == NIB_PAD)
    else $error("odd-length row tail malformed");

  AST_ROW_FLIP: assert property (
    s_row_end |=> row_odd == ~$past(row_sel))
    else $error("row parity did not alternate");

  AST_ROW_KEEP: assert property (
    acc && !pix_last && !(pix_sof && state == S_EVEN) |=> row_odd == $past(row_odd))
    else $error("row parity changed mid-row");

  AST_SOF_EVEN: assert property (
    s_even_taken ##0 pix_sof |-> push_row == ROW_EVEN)
    else $error("frame start row not even");

endmodule // bay_packer

// ===== bay_host.sv
`timescale 1ns/100ps

module bay_host
  import bay_pkg::*;
(
  // Clock
  input  wire logic       ref_clk,
  // Byte stream acceptance
  output logic            out_ready,
  // Stall control: 0 always ready, 1 random stalls, 2 blocked
  input  wire logic [1:0] mode
);
  logic [31:0] rnd = 32'h4a997f81;

  initial out_ready = 1'b0;

  // Changes off the sampling edge, so the packer sees a settled level
  always @(negedge ref_clk) begin
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    out_ready = (mode == 2'h0) || (mode == 2'h1 && rnd[3]);
  end
endmodule // bay_host

// ===== bay_tb.sv
`timescale 1ns/100ps

module tb
  import bay_pkg::*;
;
  logic              ref_clk   = 1'b0;
  logic              sys_rst   = 1'b1;
  logic              pix_valid = 1'b0;
  logic              pix_sof   = 1'b0;
  logic              pix_last  = 1'b0;
  logic [PIX_W-1:0]  pix_data  = 12'h000;
  logic              pix_ready;
  logic              out_valid;
  logic              out_ready;
  logic              out_last;
  logic              out_row_odd;
  logic [BYTE_W-1:0] out_data;
  logic [1:0]        mode      = 2'h0;
  logic              row_odd   = 1'b0;
  logic [31:0]       seed      = 32'h4a997f81;
  logic [9:0]        exp_q[$];
  logic [9:0]        got_b;
  logic [9:0]        exp_b;
  logic [PIX_W-1:0]  fix[$];
  int                mismatches = 0;
  int                cmp_count  = 0;

  always #2.5 ref_clk = ~ref_clk;

  bay_packer bay_packer_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .pix_data(pix_data), .pix_sof(pix_sof), .pix_last(pix_last),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_last(out_last),
    .out_row_odd(out_row_odd));

  bay_host bay_host_i (.ref_clk(ref_clk), .out_ready(out_ready), .mode(mode));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check_byte(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: byte got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Entered at a falling edge; valid stays up so rows can run back to back
  task automatic put(input logic [PIX_W-1:0] v, input logic l, input logic s);
    pix_valid = 1'b1;
    pix_data  = v;
    pix_last  = l;
    pix_sof   = s;
    while (pix_ready !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic row(input int n, input logic s);
    logic [PIX_W-1:0] p[$];
    if (s) row_odd = ROW_EVEN;
    for (int i = 0; i < n; i++) begin
      seed = xs(seed);
      p.push_back(i < fix.size() ? fix[i] : seed[PIX_W-1:0]);
    end
    for (int i = 0; i < n; i += 2) begin
      exp_q.push_back({i + 1 >= n ? 1'b0 : 1'b0, row_odd, p[i][11:4]});
      if (i + 1 < n) begin
        exp_q.push_back({1'b0, row_odd, p[i+1][3:0], p[i][3:0]});
        exp_q.push_back({i + 2 >= n, row_odd, p[i+1][11:4]});
      end else begin
        exp_q.push_back({1'b1, row_odd, NIB_PAD, p[i][3:0]});
      end
    end
    for (int i = 0; i < n; i++) put(p[i], i == n - 1, s && i == 0);
    row_odd = ~row_odd;
    fix = {};
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Unexpected byte is compared against its own inverse so it always counts
  always @(posedge ref_clk) begin
    if (!sys_rst && out_valid === 1'b1 && out_ready === 1'b1) begin
      got_b = {out_last, out_row_odd, out_data};
      exp_b = exp_q.size() ? exp_q.pop_front() : ~got_b;
      check_byte(got_b, exp_b);
    end
  end

  initial begin
    repeat (10) @(negedge ref_clk);
    check_flag(pix_ready, 1'b0);
    check_flag(out_valid, 1'b0);
    $display("Test reset levels done");
    sys_rst = 1'b0;
    fix = {12'h000, 12'hfff, 12'hfff, 12'h000, 12'habc, 12'h123};
    row(6, 1'b1);
    $display("Test extremes on even row done");
    mode = 2'h1;
    row(5, 1'b0);
    $display("Test odd-length odd row with stalls done");
    row(1, 1'b0);
    row(4, 1'b1);
    $display("Test frame start resets parity done");
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      row(1 + int'(seed[2:0]), 1'b0);
    end
    $display("Test random rows done");
    mode = 2'h2;
    fork
      row(6, 1'b0);
      begin
        repeat (12) @(negedge ref_clk);
        check_flag(pix_ready, 1'b0);
        mode = 2'h1;
      end
    join
    pix_valid = 1'b0;
    repeat (300) if (exp_q.size() != 0) @(negedge ref_clk);
    check_flag(exp_q.size() == 0, 1'b1);
    $display("Test full buffer with blocked host done");
    results();
  end

  // Expected run is a few hundred cycles
  initial begin
    #50us;
    mismatches++;
    $display("Error %0t: watchdog expired", $time);
    results();
  end
endmodule // tb
